// *** logic/e1_rx_overhead_pkg.sv ***
// shared constants for the e1 receive overhead capture block
// assumes a 32-bit axi4-lite register bus and eight framer ports
package e1_rx_overhead_pkg;

    // port count and per-port register stride, in register indexes
    localparam int          PORTS        = 8;
    localparam int          PORT_W       = 3;
    localparam logic [11:0] PORT_STRIDE  = 12'h200;

    // byte address fields: word index, port copy, bits that must be zero
    localparam int          AIDX_LO      = 2;
    localparam int          AIDX_HI      = 10;
    localparam int          APORT_LO     = 11;
    localparam int          APORT_HI     = 13;
    localparam int          ATOP_LO      = 14;

    // register indexes within one port (byte address is four times these)
    localparam logic [8:0]  IDX_ALIGN    = 9'h064;
    localparam logic [8:0]  IDX_NONALIGN = 9'h065;
    localparam logic [8:0]  IDX_SI_EVEN  = 9'h066;
    localparam logic [8:0]  IDX_SI_ODD   = 9'h067;
    localparam logic [8:0]  IDX_ALARM    = 9'h068;
    localparam logic [8:0]  IDX_SPARE4   = 9'h069;
    localparam logic [8:0]  IDX_SPARE5   = 9'h06A;
    localparam logic [8:0]  IDX_SPARE6   = 9'h06B;
    localparam logic [8:0]  IDX_SPARE7   = 9'h06C;
    localparam logic [8:0]  IDX_MODE     = 9'h080;

    // capture slots held per port
    localparam int          SLOTS        = 9;
    localparam logic [3:0]  SL_ALIGN     = 4'h0;
    localparam logic [3:0]  SL_NONALIGN  = 4'h1;
    localparam logic [3:0]  SL_SI_EVEN   = 4'h2;
    localparam logic [3:0]  SL_SI_ODD    = 4'h3;
    localparam logic [3:0]  SL_ALARM     = 4'h4;
    localparam logic [3:0]  SL_SPARE4    = 4'h5;
    localparam logic [3:0]  SL_SPARE5    = 4'h6;
    localparam logic [3:0]  SL_SPARE6    = 4'h7;
    localparam logic [3:0]  SL_SPARE7    = 4'h8;
    localparam logic [3:0]  SL_MODE      = 4'h9;
    localparam logic [3:0]  SL_NONE      = 4'hF;

    // bit positions inside the time slot 0 byte (first received bit = 7)
    localparam int          BIT_INTL     = 7;
    localparam int          BIT_ALARM    = 5;
    localparam int          BIT_SPARE4   = 4;
    localparam int          BIT_SPARE5   = 3;
    localparam int          BIT_SPARE6   = 2;
    localparam int          BIT_SPARE7   = 1;
    localparam int          BIT_STD_SEL  = 0;

    // multiframe positions
    localparam logic [3:0]  FRAME_FIRST  = 4'h0;
    localparam logic [3:0]  FRAME_LAST   = 4'hF;

    // reset values and bus answers
    localparam logic [7:0]  CAP_RESET    = 8'h00;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_DECERR  = 2'h3;
    localparam int          ADDR_W       = 32;
    localparam int          DATA_W       = 32;

endpackage

// *** logic/e1_rx_overhead_capture.sv ***
// overhead capture registers for eight e1 receive ports, axi4-lite slave
// assumes each framer drives a one-cycle time slot 0 strobe on mclk with
// the slot byte, the frame number in the multiframe and a sync level
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: the align word register holds the intl bit in bit 7 and the seven alignment bits below it.
// RULE2: the non-align word register shows the intl bit in 7, the marker in 6 and the alarm bit in 5.
// RULE3: the non-align word register shows spare bits four to eight in bits 4 down to 0.
// RULE4: intl bits of even frames 0 to 14 form one byte, frame 14 in bit 7 and frame 0 in bit 0.
// RULE5: intl bits of odd frames 1 to 15 form one byte, frame 15 in bit 7 and frame 1 in bit 0.
// RULE6: the alarm bit of each odd frame is kept in one byte, frame 15 in bit 7 to frame 1 in bit 0.
// RULE7: spare bit four of each odd frame is kept in one byte, frame 15 high to frame 1 low.
// RULE8: spare bit five of each odd frame is kept in one byte, frame 15 high to frame 1 low.
// RULE9: spare bit six of each odd frame is kept in one byte, higher frames in higher bits.
// RULE10: spare bit seven of each odd frame is kept in one byte, frame 15 in bit 7 and downward.
// RULE11: each of eight ports has its own copy at base plus 0x200 times port index minus one.
// RULE12: the capture registers hold e1 overhead only while the port is in e1 mode.
// RULE13: bit 0 of the receive master mode register picks the standard, 0 for t1 and 1 for e1.
// RULE14: capture registers reset to zero and update once per multiframe while sync is held.
// RULE15: reads of capture registers have no side effect and writes to them are ignored.
module e1_rx_overhead_capture
    import e1_rx_overhead_pkg::*;
(
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    // framer side, one lane per port
    input  wire logic [PORTS-1:0]            tsZeroStrobe,
    input  wire logic [PORTS-1:0][7:0]       tsZeroByte,
    input  wire logic [PORTS-1:0][3:0]       frameNum,
    input  wire logic [PORTS-1:0]            frameSync,
    output logic      [PORTS-1:0]            lineStandardE1,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [DATA_W-1:0]           s_axi_wdata,
    input  wire logic [DATA_W/8-1:0]         s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [ADDR_W-1:0]           s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [DATA_W-1:0]                s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////
    // address decode

    // register slot selected by a byte address, SL_NONE when unmapped
    function automatic logic [3:0] slotOf(input logic [ADDR_W-1:0] addr);
        logic [8:0] idx;
        logic       hiZero;
        idx    = addr[AIDX_HI:AIDX_LO];
        hiZero = (addr[ADDR_W-1:ATOP_LO] == '0)
                 && (addr[AIDX_LO-1:0] == '0);
        slotOf = SL_NONE;
        if (hiZero) begin
            unique case (idx)
                IDX_ALIGN:    slotOf = SL_ALIGN;
                IDX_NONALIGN: slotOf = SL_NONALIGN;
                IDX_SI_EVEN:  slotOf = SL_SI_EVEN;
                IDX_SI_ODD:   slotOf = SL_SI_ODD;
                IDX_ALARM:    slotOf = SL_ALARM;
                IDX_SPARE4:   slotOf = SL_SPARE4;
                IDX_SPARE5:   slotOf = SL_SPARE5;
                IDX_SPARE6:   slotOf = SL_SPARE6;
                IDX_SPARE7:   slotOf = SL_SPARE7;
                IDX_MODE:     slotOf = SL_MODE;
                default:      slotOf = SL_NONE;
            endcase
        end
    endfunction

    // port copy selected by a byte address (index bits 11:9)
    function automatic logic [PORT_W-1:0] portOf(
        input logic [ADDR_W-1:0] addr);
        portOf = addr[APORT_HI:APORT_LO]; // RULE11
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // per-port capture

    // line standard per port and every capture byte, flattened for the mux
    logic [PORTS-1:0]                 modeE1_reg;
    logic [PORTS-1:0][SLOTS-1:0][7:0] capAll;

    // standard select also goes out as a level to the framer
    assign lineStandardE1 = modeE1_reg;

    // one lane of capture logic for each port
    genvar p;
    generate
        for (p = 0; p < PORTS; p = p + 1) begin : g_port
            // per-port storage and the strobe qualifiers
            logic [7:0]  shadow_reg [SLOTS];
            logic [7:0]  cap_reg    [SLOTS];
            logic        mfValid_reg;
            logic        commit_reg;
            logic        take;
            logic        odd;
            logic [2:0]  hpos;
            logic [7:0]  slotByte;

            // a slot 0 byte counts only in e1 mode with sync held
            assign take     = tsZeroStrobe[p] && frameSync[p]
                              && modeE1_reg[p]; // RULE12 RULE13
            assign odd      = frameNum[p][0];
            assign hpos     = frameNum[p][3:1];
            assign slotByte = tsZeroByte[p];

            // multiframe qualifier: set at frame 0, lost with sync or mode
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    mfValid_reg <= 1'b0;
                end else if (!frameSync[p] || !modeE1_reg[p]) begin
                    mfValid_reg <= 1'b0; // RULE14
                end else if (take && frameNum[p] == FRAME_FIRST) begin
                    mfValid_reg <= 1'b1;
                end
            end

            // one-cycle commit after the last frame of a whole multiframe
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    commit_reg <= 1'b0;
                end else begin
                    commit_reg <= take && mfValid_reg
                                  && frameNum[p] == FRAME_LAST; // RULE14
                end
            end

            // working copy gathered frame by frame
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    for (int s = 0; s < SLOTS; s++) begin
                        shadow_reg[s] <= CAP_RESET;
                    end
                end else if (take && !odd) begin
                    // even frame: alignment word and its intl bit
                    shadow_reg[SL_ALIGN] <= slotByte; // RULE1
                    shadow_reg[SL_SI_EVEN][hpos] <=
                        slotByte[BIT_INTL]; // RULE4
                end else if (take) begin
                    // odd frame: non-alignment word and the odd histories
                    shadow_reg[SL_NONALIGN] <= slotByte; // RULE2 RULE3
                    shadow_reg[SL_SI_ODD][hpos] <=
                        slotByte[BIT_INTL]; // RULE5
                    shadow_reg[SL_ALARM][hpos] <=
                        slotByte[BIT_ALARM]; // RULE6
                    shadow_reg[SL_SPARE4][hpos] <=
                        slotByte[BIT_SPARE4]; // RULE7
                    shadow_reg[SL_SPARE5][hpos] <=
                        slotByte[BIT_SPARE5]; // RULE8
                    shadow_reg[SL_SPARE6][hpos] <=
                        slotByte[BIT_SPARE6]; // RULE9
                    shadow_reg[SL_SPARE7][hpos] <=
                        slotByte[BIT_SPARE7]; // RULE10
                end
            end

            // visible registers change only on a multiframe commit
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    for (int s = 0; s < SLOTS; s++) begin
                        cap_reg[s] <= CAP_RESET; // RULE14
                    end
                end else if (commit_reg) begin
                    for (int s = 0; s < SLOTS; s++) begin
                        cap_reg[s] <= shadow_reg[s]; // RULE14
                    end
                end
            end

            // flatten for the bus read mux
            for (genvar s = 0; s < SLOTS; s = s + 1) begin : g_slot
                assign capAll[p][s] = cap_reg[s];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel

    // write path: held halves, response and the decoded target
    logic              awHeld_reg;
    logic              wHeld_reg;
    logic [ADDR_W-1:0] awAddr_reg;
    logic [7:0]        wByte_reg;
    logic              wLane0_reg;
    logic              bValid_reg;
    logic [1:0]        bResp_reg;
    logic              doWrite;
    logic [3:0]        wSlot;
    logic [PORT_W-1:0] wPort;

    // readies drop while an item is held or the answer is open
    assign s_axi_awready = !awHeld_reg && !bValid_reg;
    assign s_axi_wready  = !wHeld_reg && !bValid_reg;
    assign s_axi_bvalid  = bValid_reg;
    assign s_axi_bresp   = bResp_reg;
    assign doWrite       = awHeld_reg && wHeld_reg && !bValid_reg;
    assign wSlot         = slotOf(awAddr_reg);
    assign wPort         = portOf(awAddr_reg);

    // address and data are taken in either order and held until used
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_reg <= 1'b0;
        end
    end

    // data byte and lane 0 strobe kept until the write is carried out
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wHeld_reg  <= 1'b0;
            wByte_reg  <= 8'h00;
            wLane0_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg  <= 1'b1;
            wByte_reg  <= s_axi_wdata[7:0];
            wLane0_reg <= s_axi_wstrb[0];
        end else if (doWrite) begin
            wHeld_reg <= 1'b0;
        end
    end

    // write response; capture slots accept and ignore the data
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bValid_reg <= 1'b0;
            bResp_reg  <= RESP_OKAY;
        end else if (doWrite) begin
            bValid_reg <= 1'b1;
            bResp_reg  <= (wSlot == SL_NONE) ? RESP_DECERR
                                             : RESP_OKAY; // RULE15
        end else if (s_axi_bready) begin
            bValid_reg <= 1'b0;
        end
    end

    // line standard select, one bit per port
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            modeE1_reg <= '0;
        end else if (doWrite && wSlot == SL_MODE && wLane0_reg) begin
            modeE1_reg[wPort] <= wByte_reg[BIT_STD_SEL]; // RULE13
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel

    // read path: registered answer and the decoded source
    logic              rValid_reg;
    logic [DATA_W-1:0] rData_reg;
    logic [1:0]        rResp_reg;
    logic [3:0]        rSlot;
    logic [PORT_W-1:0] rPort;
    logic [7:0]        rByte;

    // one read at a time; the address is decoded while it is offered
    assign s_axi_arready = !rValid_reg;
    assign s_axi_rvalid  = rValid_reg;
    assign s_axi_rdata   = rData_reg;
    assign s_axi_rresp   = rResp_reg;
    assign rSlot         = slotOf(s_axi_araddr);
    assign rPort         = portOf(s_axi_araddr);

    // read mux; t1 ports show zero in the capture slots
    always_comb begin
        rByte = 8'h00;
        if (rSlot == SL_MODE) begin
            rByte[BIT_STD_SEL] = modeE1_reg[rPort];
        end else if (rSlot != SL_NONE && modeE1_reg[rPort]) begin
            rByte = capAll[rPort][rSlot]; // RULE12
        end
    end

    // read answer one cycle after the address is taken, no side effect
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rValid_reg <= 1'b0;
            rData_reg  <= '0;
            rResp_reg  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_reg <= 1'b1;
            rData_reg  <= {{(DATA_W-8){1'b0}}, rByte}; // RULE15
            rResp_reg  <= (rSlot == SL_NONE) ? RESP_DECERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            rValid_reg <= 1'b0;
        end
    end

endmodule

// *** dv/e1_rx_overhead_capture_sva.sv ***
// bus and mode checks for the e1 overhead capture block
// assumes a bind onto the top module, ports seen by name
`timescale 1ns/1ps
module e1_rx_overhead_capture_sva
    import e1_rx_overhead_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic [PORTS-1:0]  lineStandardE1,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    // answers follow requests within the stated cycles
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write answer missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer missing");
    // answers stand until taken
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer moved");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer moved");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer open");
    a_aw_refused: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer open");
    a_rdata_upper: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_mode_cause: assert property ($changed(lineStandardE1)
        |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2))
        else $error("line standard moved without a write");
endmodule

// *** dv/e1_framer_model.sv ***
// behavioural receive framer sending slot 0 bytes of one multiframe
// assumes the bench loads sixteen bytes and pulses start once for each multiframe
`timescale 1ns/1ps
module e1_framer_model
    import e1_rx_overhead_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  start,
    input  wire logic [PORT_W-1:0]     port,
    input  wire logic [15:0][7:0]      frames,
    input  wire logic [4:0]            brk,
    output logic      [PORTS-1:0]      tsZeroStrobe = '0,
    output logic      [PORTS-1:0][7:0] tsZeroByte = '0,
    output logic      [PORTS-1:0][3:0] frameNum = '0,
    output logic      [PORTS-1:0]      frameSync = '0,
    output logic                       busy = 1'b0
);
    logic [4:0] f   = '0;
    logic [1:0] gap = '0;

    ////////////////////////////////////////////////////////////////////////
    // one byte every fourth cycle, frames in order, sync dropped at brk
    always @(posedge mclk) begin
        tsZeroStrobe <= '0;
        tsZeroByte <= ~tsZeroByte; // lines toggle between strobes
        frameNum <= ~frameNum;
        if (start && !busy) begin
            busy <= 1'b1;
            f <= '0;
            gap <= '0;
            frameSync[port] <= (brk != 5'h00);
        end else if (busy) begin
            gap <= gap + 2'h1;
            if (gap == 2'h3) begin
                tsZeroStrobe[port] <= 1'b1;
                tsZeroByte[port] <= frames[f[3:0]];
                frameNum[port] <= f[3:0];
                frameSync[port] <= (f < brk);
                f <= f + 5'h01;
                busy <= (f != 5'h0F);
            end
        end
    end
endmodule

// *** dv/e1_rx_overhead_capture_bench.sv ***
// random multiframes on every port, registers read over axi4-lite
// assumes the framer model and the checker file are compiled first
`timescale 1ns/1ps
module e1_rx_overhead_capture_bench;
    import e1_rx_overhead_pkg::*;
    logic mclk = 1'b0, rst_n = 1'b0, start = 1'b0, busy;
    logic [2:0] port = 3'h0;
    logic [4:0] brk = 5'h10;
    logic [15:0][7:0] frames = '0;
    logic [PORTS-1:0] tsZeroStrobe, frameSync, lineStandardE1;
    logic [PORTS-1:0][7:0] tsZeroByte;
    logic [PORTS-1:0][3:0] frameNum;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [15:0][7:0] mf [PORTS];
    int n_errors = 0;
    int checks = 0;

    e1_rx_overhead_capture e1_rx_overhead_capture_i (.*);
    e1_framer_model e1_framer_model_i (.*);

    initial forever #10 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    // verdict, comparison and bounded waits
    task automatic end_sim();
        if (n_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int n);
        if (n > 99) begin
            n_errors++;
            end_sim();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // bus cycles: requests held until ready, answers taken at the edge
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic aw, w, b;
        int n;
        aw = 1'b1;
        w = 1'b1;
        n = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge mclk);
            n++;
            tmo(n);
            if (s_axi_awready === 1'b1) aw = 1'b0;
            if (s_axi_wready === 1'b1) w = 1'b0;
            b = (s_axi_bvalid === 1'b1);
            rs = s_axi_bresp;
            @(posedge mclk);
            if (!aw) s_axi_awvalid <= 1'b0;
            if (!w) s_axi_wvalid <= 1'b0;
        end while (!b);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [31:0] a);
        logic ar, r;
        int n;
        ar = 1'b1;
        n = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge mclk);
            n++;
            tmo(n);
            if (s_axi_arready === 1'b1) ar = 1'b0;
            r = (s_axi_rvalid === 1'b1);
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge mclk);
            if (!ar) s_axi_arvalid <= 1'b0;
        end while (!r);
        s_axi_rready <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // expected contents worked out from the sixteen slot 0 bytes
    function automatic logic [31:0] ad(input int p, input logic [8:0] x);
        return 32'(4 * (int'(x) + int'(PORT_STRIDE) * p));
    endfunction
    function automatic logic [7:0] expv(input int i, input logic [15:0][7:0] b);
        logic [7:0] r;
        r = '0;
        for (int k = 0; k < 8; k++) begin
            if (i == 2) r[k] = b[2*k][7];
            if (i == 3) r[k] = b[2*k+1][7];
            if (i > 3) r[k] = b[2*k+1][(i == 4) ? 5 : 9 - i];
        end
        if (i == 0) r = b[14];
        if (i == 1) r = b[15];
        return r;
    endfunction
    task automatic chkport(input int p, input logic e1);
        for (int i = 0; i < SLOTS; i++) begin
            rdr(ad(p, IDX_ALIGN + 9'(i)));
            chk(rd, e1 ? {24'h0, expv(i, mf[p])} : 32'h0);
            chk({30'h0, rs}, {30'h0, RESP_OKAY});
        end
    endtask
    task automatic mframe(input int p, input logic [4:0] k, input logic keep);
        logic [15:0][7:0] b;
        int n;
        for (int f = 0; f < 16; f++)
            b[f] = (f % 2) ? {1'($urandom), 1'b1, 6'($urandom)}
                           : {1'($urandom), 7'h1B};
        port <= 3'(p);
        brk <= k;
        frames <= b;
        start <= 1'b1;
        if (keep) mf[p] = b;
        @(posedge mclk);
        start <= 1'b0;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
            tmo(n);
        end while (busy !== 1'b0);
        repeat (3) @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(72978));
        for (int p = 0; p < PORTS; p++) mf[p] = '0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        chk(32'(lineStandardE1), 32'h0);
        chkport(0, 1'b1);
        for (int p = 0; p < PORTS; p++) begin
            wr(ad(p, IDX_MODE), 32'h1);
            chk({31'h0, lineStandardE1[p]}, 32'h1);
            rdr(ad(p, IDX_MODE));
            chk(rd, 32'h1);
            mframe(p, 5'h10, 1'b1);
            chkport(p, 1'b1);
        end
        mframe(0, 5'h05, 1'b0);
        chkport(0, 1'b1);
        wr(ad(2, IDX_ALIGN), 32'hFF);
        chk({30'h0, rs}, {30'h0, RESP_OKAY});
        chkport(2, 1'b1);
        wr(ad(0, IDX_MODE), 32'h0);
        chk({31'h0, lineStandardE1[0]}, 32'h0);
        mframe(0, 5'h10, 1'b0);
        chkport(0, 1'b0);
        wr(ad(0, IDX_MODE), 32'h1);
        chkport(0, 1'b1);
        rdr(ad(0, 9'h070));
        chk({rd[31:2], rs}, {30'h0, RESP_DECERR});
        wr(32'h0004_0000, 32'h1);
        chk({30'h0, rs}, {30'h0, RESP_DECERR});
        // second reset in mid-run: captures and modes back to zero
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        chk(32'(lineStandardE1), 32'h0);
        mf[3] = '0;
        wr(ad(3, IDX_MODE), 32'h1);
        chkport(3, 1'b1);
        mframe(3, 5'h10, 1'b1);
        chkport(3, 1'b1);
        end_sim();
    end
endmodule

bind e1_rx_overhead_capture e1_rx_overhead_capture_sva
    e1_rx_overhead_capture_sva_i (.*);
